// ===== fprs_regs.svh
`ifndef FPRS_REGS_SVH
`define FPRS_REGS_SVH
// ****************************************
// timing
// ****************************************
`define FPRS_CLK_HZ           40000000
`define FPRS_QUAL_TIME_US     10000
`define FPRS_QUAL_CYCLES      ((`FPRS_QUAL_TIME_US * 40) )
`define FPRS_RST_DELAY_US     160000
`define FPRS_RST_CYCLES       ((`FPRS_RST_DELAY_US * 40) )
`define FPRS_FILT_TIME_NS     30000
`define FPRS_FILT_CYCLES      ((`FPRS_FILT_TIME_NS + 24) / 25)
// ****************************************
// personalities
// ****************************************
`define FPRS_PERS_TIMED       2'h0
`define FPRS_PERS_INDEP       2'h1
`define FPRS_PERS_FIXED       2'h2
`define FPRS_PERS_GROUP       2'h3
`endif

// ===== fprs_pkg.sv
package fprs_pkg;
  typedef enum logic [1:0] {
    FPRS_IDLE = 2'b00,
    FPRS_QUAL = 2'b01,
    FPRS_ON   = 2'b10,
    FPRS_OFF  = 2'b11
  } fprs_state_t;

  // per-channel comparator events replacing the analog ramps
  typedef struct packed {
    logic [3:0] on_delay_done;
    logic [3:0] off_delay_done;
    logic [3:0] gate_full;
    logic [3:0] gate_low;
  } fprs_events_t;
endpackage : fprs_pkg

// ===== fprs_top.sv
`timescale 1ns/1ps
`include "fprs_regs.svh"
// How it works
// RULE1: start only after enable and all rails good continuously for 10ms.
// RULE2: on-delay timers start together; each gate turns on at its threshold.
// RULE3: all gates fully on, wait 160ms, then release reset high.
// RULE4: rail low beyond glitch filter: reset low, shutdown low, all gates off.
// RULE5: enable removed without fault: reset low, all off-delay timers start.
// RULE6: off-delay threshold sets channel off latch, turning its gate off.
// RULE7: enable polarity is a parameter; active-high variant sleeps when off.
// RULE8: independent mode: each gate on when enable and its rail good.
// RULE9: independent mode: reset released 160ms after all gates fully on.
// RULE10: independent mode: a rail drop drops only its gate and reset.
// RULE11: independent mode: disable latches reset low, sequenced turn-off.
// RULE12: fixed mode: A,B,C,D on, each after previous nears full; 160ms reset.
// RULE13: fixed mode: any rail low drops reset, shutdown line, all gates.
// RULE14: fixed mode: off D first, then C, B, A after previous goes low.
// RULE15: grouped mode: all rails, both enables; A-D on after 10ms, in order.
// RULE16: grouped mode: reset released 160ms after gate D fully on.
// RULE17: grouped mode: fault drops only its group; enable cycle restarts it. Code drops seq_done_n of both groups.
// RULE18: grouped mode: disable turns each group off in reverse order.
// RULE19: shutdown line pulled low externally: all gates off, reset low.
// RULE20: shutdown line release with all conditions met skips qualification.
// RULE21: filtered fault pulls the wired-AND shutdown line low.
// RULE22: restart is automatic except grouped mode after a fault.
// RULE23: thresholds and gate levels arrive as per-channel event inputs.
module fprs_top #(
  parameter logic [1:0] PERSONALITY  = `FPRS_PERS_TIMED,
  parameter bit         ENABLE_HIGH  = 1'b1,
  parameter int         QUAL_CYCLES  = `FPRS_QUAL_CYCLES,
  parameter int         RST_CYCLES   = `FPRS_RST_CYCLES,
  parameter int         FILT_CYCLES  = `FPRS_FILT_CYCLES
) (
  input  wire logic                  mclk,
  input  wire logic                  reset,
  input  wire logic [1:0]            enable_pin,
  input  wire logic [3:0]            rail_monitor,
  input  wire fprs_pkg::fprs_events_t events,
  input  wire logic                  shared_shutdown_line_in,
  output logic                       shared_shutdown_line_out,
  output logic                       shared_shutdown_line_oe,
  output logic [3:0]                 gate_on,
  output logic [3:0]                 gate_strong_off,
  output logic [3:0]                 on_delay_timer_run,
  output logic [3:0]                 off_delay_timer_run,
  output logic [1:0]                 seq_done_n,
  output logic                       sleep
);
  initial begin
    if (QUAL_CYCLES < 1 || RST_CYCLES < 1 || FILT_CYCLES < 1)
      $error("fprs_top: cycle counts must be at least one");
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [1:0]  en_s1, en_s2;
  logic [3:0]  rail_s1, rail_s2;
  logic        sd_s1, sd_s2;
  fprs_pkg::fprs_events_t ev_s1, ev_s2;
  always_ff @(posedge mclk) begin
    en_s1   <= enable_pin;
    en_s2   <= en_s1;
    rail_s1 <= rail_monitor;
    rail_s2 <= rail_s1;
    sd_s1   <= shared_shutdown_line_in;
    sd_s2   <= sd_s1;
    ev_s1   <= events; // [RULE23]
    ev_s2   <= ev_s1;
  end

  // enable asserted per group; polarity is a build choice
  logic [1:0] en_ok;
  assign en_ok = ENABLE_HIGH ? en_s2 : ~en_s2; // [RULE7]

  localparam bit INDEP = (PERSONALITY == `FPRS_PERS_INDEP);
  localparam bit FIXED = (PERSONALITY == `FPRS_PERS_FIXED);
  localparam bit GROUP = (PERSONALITY == `FPRS_PERS_GROUP);

  // group of each channel: A,B -> 0, C,D -> 1
  function automatic logic [1:0] grp_mask(input logic [3:0] ch);
    grp_mask = {|ch[3:2], |ch[1:0]};
  endfunction : grp_mask

  logic enable_all;
  assign enable_all = GROUP ? (&en_ok) : en_ok[0];

  // ****************************************
  // glitch filter on rails
  // ****************************************
  logic [3:0]  rail_fault;
  logic [31:0] filt_cnt [4];
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 4; i++) begin
      if (reset || rail_s2[i]) begin
        filt_cnt[i]   <= 32'h0;
        rail_fault[i] <= 1'b0;
      end else if (filt_cnt[i] >= FILT_CYCLES) begin
        rail_fault[i] <= 1'b1; // [RULE4]
      end else begin
        filt_cnt[i] <= filt_cnt[i] + 32'h1;
      end
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  fprs_pkg::fprs_state_t state;
  logic [31:0] qual_cnt, rst_cnt;
  logic [3:0]  on_latch, off_latch;
  logic [1:0]  grp_locked;
  logic        fault_hit, ext_shut, sd_prev;
  logic [3:0]  fault_ch;

  // a fault seen while gates are up; independent mode handles it per channel
  assign fault_ch  = rail_fault & (on_latch | on_delay_timer_run);
  assign fault_hit = !INDEP && (|fault_ch);
  assign ext_shut  = !sd_s2 && !shared_shutdown_line_oe; // [RULE19]

  always_ff @(posedge mclk) begin
    sd_prev <= sd_s2;
  end

  // next channel allowed to start ramping in ordered modes
  function automatic logic [3:0] ordered_go(input logic [3:0] full);
    ordered_go = {full[2], full[1], full[0], 1'b1};
  endfunction : ordered_go

  logic [3:0] go_on;
  always_comb begin
    if (FIXED || GROUP)
      go_on = ordered_go(ev_s2.gate_full); // [RULE12] [RULE15]
    else
      go_on = 4'hf;
  end

  // reverse-order off permission
  logic [3:0] go_off;
  always_comb begin
    if (FIXED)
      go_off = {1'b1, ev_s2.gate_low[3], ev_s2.gate_low[2],
                ev_s2.gate_low[1]}; // [RULE14]
    else if (GROUP)
      go_off = {1'b1, ev_s2.gate_low[3], 1'b1, ev_s2.gate_low[1]}; // [RULE18]
    else
      go_off = 4'hf;
  end

  logic all_ok;
  assign all_ok = enable_all && (&rail_s2) && sd_s2 && !(|grp_locked);

  always_ff @(posedge mclk) begin
    if (reset) begin
      state               <= fprs_pkg::FPRS_IDLE;
      qual_cnt            <= 32'h0;
      on_latch            <= 4'h0;
      off_latch           <= 4'h0;
      on_delay_timer_run  <= 4'h0;
      off_delay_timer_run <= 4'h0;
      gate_strong_off     <= 4'h0;
    end else if (ext_shut || fault_hit) begin
      // strong pull-down at once: all gates, or only the faulted group on a grouped-mode fault [RULE4] [RULE13] [RULE19]
      state               <= fprs_pkg::FPRS_IDLE;
      qual_cnt            <= 32'h0;
      on_latch            <= GROUP ? (on_latch & ~{{2{grp_mask(fault_ch)[1]}},
                                       {2{grp_mask(fault_ch)[0]}}}) : 4'h0;
      on_delay_timer_run  <= 4'h0;
      off_delay_timer_run <= 4'h0;
      off_latch           <= 4'h0;
      gate_strong_off     <= GROUP && !ext_shut ?
                             {{2{grp_mask(fault_ch)[1]}},
                              {2{grp_mask(fault_ch)[0]}}} : 4'hf; // [RULE17]
    end else begin
      unique case (state)
        fprs_pkg::FPRS_IDLE: begin
          off_latch <= 4'h0;
          if (ev_s2.gate_low == 4'hf)
            gate_strong_off <= 4'h0;
          if (INDEP && en_ok[0]) begin
            state <= fprs_pkg::FPRS_ON; // [RULE8]
          end else if (all_ok) begin
            gate_strong_off <= 4'h0;
            if (!sd_prev) begin
              state              <= fprs_pkg::FPRS_ON; // [RULE20]
              on_delay_timer_run <= 4'h1 | (FIXED||GROUP ? 4'h0 : 4'hf);
            end else begin
              state    <= fprs_pkg::FPRS_QUAL;
              qual_cnt <= 32'h0;
            end
          end
        end
        fprs_pkg::FPRS_QUAL: begin
          if (!all_ok) begin
            state <= fprs_pkg::FPRS_IDLE; // [RULE22]
          end else if (qual_cnt >= QUAL_CYCLES - 1) begin
            state              <= fprs_pkg::FPRS_ON; // [RULE1]
            on_delay_timer_run <= (FIXED || GROUP) ? 4'h1 : 4'hf; // [RULE2]
          end else begin
            qual_cnt <= qual_cnt + 32'h1;
          end
        end
        fprs_pkg::FPRS_ON: begin
          if (!enable_all) begin
            state               <= fprs_pkg::FPRS_OFF;
            on_delay_timer_run  <= 4'h0;
            off_delay_timer_run <= 4'hf; // [RULE5] [RULE11]
          end else if (INDEP) begin
            on_latch        <= rail_s2; // [RULE8] [RULE10]
            gate_strong_off <= ~rail_s2;
          end else begin
            for (int i = 0; i < 4; i++) begin
              if (on_delay_timer_run[i] && ev_s2.on_delay_done[i]) begin
                on_latch[i]           <= 1'b1; // [RULE2]
                on_delay_timer_run[i] <= 1'b0;
              end else if (!on_latch[i] && go_on[i] && (FIXED || GROUP) &&
                           i > 0 && on_latch[i-1]) begin
                on_delay_timer_run[i] <= 1'b1; // [RULE12] [RULE15]
              end
            end
          end
        end
        fprs_pkg::FPRS_OFF: begin
          for (int i = 0; i < 4; i++) begin
            if (off_delay_timer_run[i] && ev_s2.off_delay_done[i] &&
                go_off[i]) begin
              off_latch[i]           <= 1'b1; // [RULE6]
              on_latch[i]            <= 1'b0;
              off_delay_timer_run[i] <= 1'b0;
            end
          end
          if (off_delay_timer_run == 4'h0)
            state <= fprs_pkg::FPRS_IDLE; // [RULE22]
        end
        default: state <= fprs_pkg::FPRS_IDLE;
      endcase
    end
  end

  // ****************************************
  // group lockout after fault
  // ****************************************
  always_ff @(posedge mclk) begin
    if (reset || !GROUP) begin
      grp_locked <= 2'h0;
    end else begin
      for (int g = 0; g < 2; g++) begin
        if (grp_mask(fault_ch)[g] && !ext_shut)
          grp_locked[g] <= 1'b1; // [RULE17]
        else if (!en_ok[g])
          grp_locked[g] <= 1'b0;
      end
    end
  end

  // ****************************************
  // reset release delay
  // ****************************************
  logic [3:0] need_full;
  assign need_full = (FIXED || GROUP) ? 4'h8 : 4'hf;
  logic full_ok;
  assign full_ok = ((ev_s2.gate_full & on_latch & need_full) == need_full) &&
                   (state == fprs_pkg::FPRS_ON) && enable_all;

  always_ff @(posedge mclk) begin
    if (reset || !full_ok || (INDEP && !(&on_latch))) begin
      rst_cnt <= 32'h0;
    end else if (rst_cnt < RST_CYCLES) begin
      rst_cnt <= rst_cnt + 32'h1; // [RULE3] [RULE9] [RULE16]
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      seq_done_n <= 2'h0;
    end else if (GROUP) begin
      for (int g = 0; g < 2; g++)
        seq_done_n[g] <= (rst_cnt >= RST_CYCLES) && !grp_locked[g] &&
                         (&on_latch[2*g +: 2]); // [RULE16] [RULE17]
    end else begin
      seq_done_n <= {2{rst_cnt >= RST_CYCLES}}; // [RULE3] [RULE5]
    end
  end

  // gates being pulled down this cycle; masks the drive so that the
  // registered gate drive never overlaps the strong pull-down
  logic [1:0] fgrp;
  logic [3:0] kill;
  assign fgrp = grp_mask(fault_ch);
  always_comb begin
    if (ext_shut)
      kill = 4'hf; // [RULE19]
    else if (fault_hit)
      kill = GROUP ? {{2{fgrp[1]}}, {2{fgrp[0]}}} : 4'hf; // [RULE4]
    else if (INDEP && state == fprs_pkg::FPRS_ON)
      kill = ~rail_s2; // [RULE10]
    else
      kill = 4'h0;
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      gate_on                  <= 4'h0;
      shared_shutdown_line_out <= 1'b0;
      shared_shutdown_line_oe  <= 1'b0;
      sleep                    <= 1'b0;
    end else begin
      gate_on <= on_latch & ~off_latch & ~gate_strong_off & ~kill;
      shared_shutdown_line_out <= 1'b0;
      // wired-AND: drive low only on a filtered fault [RULE21]
      shared_shutdown_line_oe  <= fault_hit ||
                                  (shared_shutdown_line_oe && |rail_fault);
      sleep <= ENABLE_HIGH && !en_s2[0] &&
               (state == fprs_pkg::FPRS_IDLE); // [RULE7]
    end
  end
endmodule : fprs_top

// ===== fprs_top_properties.sv
`timescale 1ns/1ps
// ****************************************
// port checker
// ****************************************
module fprs_top_properties (
  input wire logic                   mclk,
  input wire logic                   reset,
  input wire logic [1:0]             enable_pin,
  input wire logic [3:0]             rail_monitor,
  input wire fprs_pkg::fprs_events_t events,
  input wire logic                   shared_shutdown_line_in,
  input wire logic                   shared_shutdown_line_out,
  input wire logic                   shared_shutdown_line_oe,
  input wire logic [3:0]             gate_on,
  input wire logic [3:0]             gate_strong_off,
  input wire logic [3:0]             on_delay_timer_run,
  input wire logic [3:0]             off_delay_timer_run,
  input wire logic [1:0]             seq_done_n,
  input wire logic                   sleep
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  property p_oe_low;
    shared_shutdown_line_oe |-> !shared_shutdown_line_out;
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("line driven high");
  property p_release;
    $rose(seq_done_n[0]) |-> gate_on == 4'hf && events.gate_full == 4'hf;
  endproperty
  a_release: assert property (p_release) else $error("early release");
  property p_pair;
    seq_done_n[0] == seq_done_n[1];
  endproperty
  a_pair: assert property (p_pair) else $error("reset bits differ");
  property p_together;
    $rose(|on_delay_timer_run) |-> on_delay_timer_run == 4'hf;
  endproperty
  a_together: assert property (p_together) else $error("timers apart");
  property p_ext_off;
    (!shared_shutdown_line_in)[*6] |-> gate_on == 4'h0 && seq_done_n == 2'h0;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("line low ignored");
  property p_oe_gates;
    $rose(shared_shutdown_line_oe) |-> ##[0:2] gate_on == 4'h0;
  endproperty
  a_oe_gates: assert property (p_oe_gates) else $error("gates stay on");
  property p_fault;
    seq_done_n[0] ##1 (rail_monitor != 4'hf)[*8] |->
      ##[0:3] shared_shutdown_line_oe;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not driven");
  property p_disable;
    seq_done_n[0] ##1 (!enable_pin[0])[*3] |-> ##[0:2] seq_done_n == 2'h0;
  endproperty
  a_disable: assert property (p_disable) else $error("reset not low");
  property p_no_fight;
    (gate_on & gate_strong_off) == 4'h0;
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("drive fight");
  c_done: cover property ($rose(seq_done_n[0]));
  c_fault: cover property ($rose(shared_shutdown_line_oe));
  c_sleep: cover property ($rose(sleep));
endmodule : fprs_top_properties

// ===== fprs_partner.sv
`timescale 1ns/1ps
// ****************************************
// switches, ramps and shutdown wire
// ****************************************
module fprs_partner (
  input  wire logic                  mclk,
  input  wire logic [3:0]            gate_on,
  input  wire logic [3:0]            on_run,
  input  wire logic [3:0]            off_run,
  input  wire logic                  line_out,
  input  wire logic                  line_oe,
  input  wire logic                  ext_low,
  output fprs_pkg::fprs_events_t     events,
  output logic                       line
);
  logic [7:0] on_cnt [4] = '{default: 8'h00};
  logic [7:0] off_cnt [4] = '{default: 8'h00};
  logic [3:0] g1 = 4'h0;
  logic [3:0] g2 = 4'h0;
  // ramps: A shortest on, D shortest off, so order is visible
  always @(negedge mclk) begin
    g1 <= gate_on;
    g2 <= g1;
    for (int i = 0; i < 4; i++) begin
      on_cnt[i] <= on_run[i] ? on_cnt[i] + 8'h01 : 8'h00;
      off_cnt[i] <= off_run[i] ? off_cnt[i] + 8'h01 : 8'h00;
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      events.on_delay_done[i] = on_cnt[i] >= 8'(3 * (i + 1));
      events.off_delay_done[i] = off_cnt[i] >= 8'(3 * (4 - i));
    end
    // gate level lags the drive by two cycles either way
    events.gate_full = g2 & gate_on;
    events.gate_low = ~g2 & ~gate_on;
  end
  // wired-and with pull-up
  assign line = (ext_low || (line_oe && !line_out)) ? 1'b0 : 1'b1;
endmodule : fprs_partner

// ===== four_rail_power_sequencer_tb.sv
`timescale 1ns/1ps
module four_rail_power_sequencer_tb;
  localparam int QUAL = 20;
  localparam int RST  = 40;
  logic                   mclk         = 1'b0;
  logic                   reset        = 1'b1;
  logic [1:0]             enable_pin   = 2'h0;
  logic [3:0]             rail_monitor = 4'h0;
  logic                   ext_low      = 1'b0;
  logic                   line;
  logic                   line_out;
  logic                   line_oe;
  logic                   sleep;
  logic [3:0]             gate_on;
  logic [3:0]             strong_off;
  logic [3:0]             on_run;
  logic [3:0]             off_run;
  logic [1:0]             seq_done_n;
  fprs_pkg::fprs_events_t events;
  int                     fails        = 0;
  int                     tests_run    = 0;
  always #12.5 mclk = ~mclk;
  fprs_top #(.QUAL_CYCLES(QUAL), .RST_CYCLES(RST), .FILT_CYCLES(5)) i_dut (
    .mclk(mclk), .reset(reset), .enable_pin(enable_pin),
    .rail_monitor(rail_monitor), .events(events),
    .shared_shutdown_line_in(line), .shared_shutdown_line_out(line_out),
    .shared_shutdown_line_oe(line_oe), .gate_on(gate_on),
    .gate_strong_off(strong_off), .on_delay_timer_run(on_run),
    .off_delay_timer_run(off_run), .seq_done_n(seq_done_n), .sleep(sleep));
  fprs_partner i_partner (
    .mclk(mclk), .gate_on(gate_on), .on_run(on_run), .off_run(off_run),
    .line_out(line_out), .line_oe(line_oe), .ext_low(ext_low),
    .events(events), .line(line));
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  // counts are bench-made, so plain int is safe here
  task automatic check_in(input string nm, input int lo, input int hi, input int g);
    tests_run++;
    if (g < lo || g > hi) begin
      fails++;
      $display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : check_in
  task automatic measure_release(output int n);
    n = 0;
    while (events.gate_full !== 4'hf && n < 200) begin @(negedge mclk); n++; end
    n = 0;
    while (seq_done_n[0] !== 1'b1 && n < 200) begin @(negedge mclk); n++; end
  endtask : measure_release
  task automatic t_startup;
    int n;
    enable_pin = 2'h3;
    rail_monitor = 4'hf;
    n = 0;
    while (on_run === 4'h0 && n < 100) begin @(negedge mclk); n++; end
    check_in("qualify", QUAL, QUAL + 4, n);
    while (gate_on === 4'h0 && n < 200) begin @(negedge mclk); n++; end
    check("first gate", 32'h1, gate_on);
    measure_release(n);
    check_in("release", RST, RST + 5, n);
  endtask : t_startup
  task automatic t_glitch_fault;
    int n;
    rail_monitor = 4'hb;
    repeat (3) @(negedge mclk);
    rail_monitor = 4'hf;
    repeat (10) @(negedge mclk);
    check("glitch", 32'h3, seq_done_n);
    rail_monitor = 4'hb;
    repeat (12) @(negedge mclk);
    check("fault oe", 32'h1, line_oe);
    check("fault gates", 32'h0, gate_on);
    check("fault strong", 32'hf, strong_off);
    check("fault reset", 32'h0, seq_done_n);
    rail_monitor = 4'hf;
    measure_release(n);
    check_in("restart", RST, RST + 5, n);
  endtask : t_glitch_fault
  task automatic t_ext;
    int n;
    ext_low = 1'b1;
    repeat (6) @(negedge mclk);
    check("ext gates", 32'h0, gate_on);
    check("ext reset", 32'h0, seq_done_n);
    ext_low = 1'b0;
    n = 0;
    while (on_run === 4'h0 && n < 100) begin @(negedge mclk); n++; end
    check_in("no wait", 0, 6, n);
    measure_release(n);
    check_in("ext release", RST, RST + 5, n);
  endtask : t_ext
  task automatic t_disable;
    int n;
    enable_pin = 2'h0;
    repeat (4) @(negedge mclk);
    check("off reset", 32'h0, seq_done_n);
    check("off timers", 32'hf, off_run);
    n = 0;
    while (gate_on === 4'hf && n < 100) begin @(negedge mclk); n++; end
    check("first off", 32'h7, gate_on);
    while (sleep !== 1'b1 && n < 200) begin @(negedge mclk); n++; end
    check("all off", 32'h0, gate_on);
    check("sleep", 32'h1, sleep);
  endtask : t_disable
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20) @(negedge mclk);
    reset = 1'b0;
    t_startup;
    t_glitch_fault;
    t_ext;
    t_disable;
    report_and_stop;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    report_and_stop;
  end
endmodule : four_rail_power_sequencer_tb
bind fprs_top fprs_top_properties i_props (
  .mclk(mclk), .reset(reset), .enable_pin(enable_pin),
  .rail_monitor(rail_monitor), .events(events),
  .shared_shutdown_line_in(shared_shutdown_line_in),
  .shared_shutdown_line_out(shared_shutdown_line_out),
  .shared_shutdown_line_oe(shared_shutdown_line_oe), .gate_on(gate_on),
  .gate_strong_off(gate_strong_off), .on_delay_timer_run(on_delay_timer_run),
  .off_delay_timer_run(off_delay_timer_run), .seq_done_n(seq_done_n),
  .sleep(sleep));
